// ===== rtl/acscfg_top.sv
/*
  audio codec serial configuration block: register slave plus the link-side steering.
  assumes frame_sync and link samples are driven on link_clk; detect pin is asynchronous.
*/
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module acscfg_top
  import acscfg_pkg::*;
#(
  parameter int W = ACSCFG_SAMPLE_W
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  input  wire logic         spdif_detect_pin,
  output logic              spdif_enable,
  input  wire logic         link_clk,
  input  wire logic         frame_sync,
  input  wire logic [W-1:0] link_front_l,
  input  wire logic [W-1:0] link_front_r,
  input  wire logic [W-1:0] link_surr_l,
  input  wire logic [W-1:0] link_surr_r,
  input  wire logic [W-1:0] link_center,
  input  wire logic [W-1:0] link_lfe,
  input  wire logic [W-1:0] link_spdif_l,
  input  wire logic [W-1:0] link_spdif_r,
  input  wire logic [W-1:0] adc_l,
  input  wire logic [W-1:0] adc_r,
  input  wire logic         spdif_underrun,
  input  wire logic         front_rate_req,
  input  wire logic         spdif_rate_req,
  input  wire logic         audio_irq,
  output logic [W-1:0]      front_dac_l,
  output logic [W-1:0]      front_dac_r,
  output logic [W-1:0]      surr_dac_l,
  output logic [W-1:0]      surr_dac_r,
  output logic [W-1:0]      center_pin,
  output logic [W-1:0]      lfe_pin,
  output logic [W-1:0]      spdif_l,
  output logic [W-1:0]      spdif_r,
  output logic              spdif_req,
  output logic              irq_slot12_bit0,
  output logic              irq_slot6_valid,
  output logic [2:0]        mic_pin_sel,
  output logic              mic_stereo,
  output logic [3:0]        chain_codec_mask,
  output logic              slot16_mode
);
  localparam logic [W-1:0] MID = {1'b1, {(W-1){1'b0}}};

  // mic_pin_sel lanes: bit 0 mic pins, bit 1 line-in pins, bit 2 center/lfe pins
  typedef struct packed {
    logic         rs_m;
    logic         rs_s;
    logic         ce_m;
    logic         ce_s;
    logic         req_m;
    logic         req_s;
    logic         ack;
    acscfg_xfer_t stage;
    acscfg_xfer_t act;
    logic [W-1:0] front_l;
    logic [W-1:0] front_r;
    logic [W-1:0] surr_l;
    logic [W-1:0] surr_r;
    logic [W-1:0] center;
    logic [W-1:0] lfe;
    logic [W-1:0] sp_l;
    logic [W-1:0] sp_r;
    logic         sp_req;
    logic         irq12;
    logic         irq6;
    logic [2:0]   mic_sel;
    logic         mic_st;
    logic [3:0]   mask;
    logic         slot16;
  } acscfg_link_t;

  acscfg_link_t q;
  acscfg_link_t d;
  acscfg_link_t f;
  acscfg_link_t rst_val;
  acscfg_if     xbus ();

  logic [W-1:0] ch_center;
  logic [W-1:0] ch_lfe;
  acscfg_xfer_t c;

  acscfg_regs u_regs (
    .clk          (clk),
    .reset_n      (reset_n),
    .ce           (ce),
    .hsel         (hsel),
    .haddr        (haddr[7:0]),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hrdata       (hrdata),
    .spdif_enable (spdif_enable),
    .detect_pin   (spdif_detect_pin),
    .bus          (xbus.regs)
  );

  // only single word transfers are issued, so hsize is not decoded
  assign hresp = 1'b0;

  always_comb begin
    rst_val = '0;
    rst_val.stage = ACSCFG_XFER_RST; // RULE_16
    rst_val.act   = ACSCFG_XFER_RST;
    rst_val.mask  = {ACSCFG_CFG_RST[ACSCFG_B_MASK3], ACSCFG_CFG_RST[ACSCFG_B_MASK+:3]};
    rst_val.slot16 = ACSCFG_CFG_RST[ACSCFG_B_SLOT16];
    rst_val.mic_sel = 3'h1;
  end

  always_comb begin
    f = q;
    c = q.stage;
    ch_center = link_center;
    ch_lfe = link_lfe;
    if (q.req_s != q.ack) begin
      // word has been stable for two link edges before the toggle is seen
      f.stage = xbus.word;
      f.ack = q.req_s;
    end
    f.sp_req = q.act.cfg[ACSCFG_B_LINK] ? front_rate_req : spdif_rate_req; // RULE_01
    if (frame_sync) begin
      f.act = c; // RULE_18
      f.front_l = link_front_l;
      f.front_r = link_front_r;
      f.surr_l = link_surr_l;
      f.surr_r = link_surr_r;
      if (c.lbk_en) begin // RULE_09
        case (c.cfg[ACSCFG_B_LBK+:2])
          ACSCFG_LBK_FRONT: begin // RULE_07
            f.front_l = adc_l;
            f.front_r = adc_r;
          end
          ACSCFG_LBK_SURR: begin // RULE_07
            f.surr_l = adc_l;
            f.surr_r = adc_r;
          end
          ACSCFG_LBK_CL: begin // RULE_08
            ch_center = adc_l;
            ch_lfe = adc_r;
          end
          default: ; // RULE_17
        endcase
      end
      if (c.cfg[ACSCFG_B_SWAP]) begin // RULE_05
        f.center = ch_lfe;
        f.lfe = ch_center;
      end else begin
        f.center = ch_center;
        f.lfe = ch_lfe;
      end
      if (spdif_underrun) begin // RULE_02
        f.sp_l = c.cfg[ACSCFG_B_FILL] ? MID : q.sp_l;
        f.sp_r = c.cfg[ACSCFG_B_FILL] ? MID : q.sp_r;
      end else if (c.cfg[ACSCFG_B_SRC]) begin // RULE_04
        f.sp_l = adc_l;
        f.sp_r = adc_r;
      end else begin
        f.sp_l = link_spdif_l;
        f.sp_r = link_spdif_r;
      end
      // steering only: the interrupt itself comes from audio_irq
      f.irq12 = audio_irq & ~c.cfg[ACSCFG_B_IRQ]; // RULE_06
      f.irq6 = audio_irq & c.cfg[ACSCFG_B_IRQ]; // RULE_06
      case (c.cfg[ACSCFG_B_MIC+:3]) // RULE_11
        3'h0:    f.mic_sel = 3'h1;
        3'h1:    f.mic_sel = 3'h2;
        3'h2:    f.mic_sel = 3'h4;
        3'h3:    f.mic_sel = 3'h4;
        3'h4:    f.mic_sel = 3'h5;
        3'h5:    f.mic_sel = 3'h3;
        3'h6:    f.mic_sel = 3'h6;
        default: f.mic_sel = 3'h7;
      endcase
      // mic mix overrides the two-channel request
      f.mic_st = c.stereo & ~c.mix; // RULE_12
      f.mask = {c.cfg[ACSCFG_B_MASK3], c.cfg[ACSCFG_B_MASK+:3]}; // RULE_13
      f.slot16 = c.cfg[ACSCFG_B_SLOT16]; // RULE_14
    end
  end

  always_comb begin
    if (!q.rs_s) begin
      d = rst_val;
    end else if (!q.ce_s) begin
      d = q;
    end else begin
      d = f;
    end
    // synchronisers run even while frozen so the freeze can be released
    d.rs_m = reset_n;
    d.rs_s = q.rs_m;
    d.ce_m = ce;
    d.ce_s = q.ce_m;
    d.req_m = xbus.req_tgl;
    d.req_s = q.req_m;
    if (!q.rs_s) begin
      d.req_s = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign xbus.ack_tgl     = q.ack;
  assign front_dac_l      = q.front_l;
  assign front_dac_r      = q.front_r;
  assign surr_dac_l       = q.surr_l;
  assign surr_dac_r       = q.surr_r;
  assign center_pin       = q.center;
  assign lfe_pin          = q.lfe;
  assign spdif_l          = q.sp_l;
  assign spdif_r          = q.sp_r;
  assign spdif_req        = q.sp_req;
  assign irq_slot12_bit0  = q.irq12;
  assign irq_slot6_valid  = q.irq6;
  assign mic_pin_sel      = q.mic_sel;
  assign mic_stereo       = q.mic_st;
  assign chain_codec_mask = q.mask;
  assign slot16_mode      = q.slot16;

  logic fe;
  logic run;
  assign run = q.rs_s && q.ce_s;
  assign fe = frame_sync && run;

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!q.rs_s);

  a_link_req: assert property (run && q.act.cfg[ACSCFG_B_LINK] // RULE_01
    |=> spdif_req == $past(front_rate_req))
    else $error("s/pdif request not tied to front rate");
  a_fill_mid: assert property (fe && spdif_underrun && q.stage.cfg[ACSCFG_B_FILL] // RULE_02
    |=> spdif_l == MID && spdif_r == MID)
    else $error("underrun did not send midscale");
  a_fill_rep: assert property (fe && spdif_underrun && !q.stage.cfg[ACSCFG_B_FILL] // RULE_02
    |=> $stable(spdif_l) && $stable(spdif_r))
    else $error("underrun did not repeat last sample");
  a_src_adc: assert property (fe && !spdif_underrun && q.stage.cfg[ACSCFG_B_SRC] // RULE_04
    |=> spdif_l == $past(adc_l))
    else $error("s/pdif not taken from adc stream");
  a_swap_pins: assert property (fe && q.stage.cfg[ACSCFG_B_SWAP] && !q.stage.lbk_en // RULE_05
    |=> center_pin == $past(link_lfe) && lfe_pin == $past(link_center))
    else $error("center and lfe not exchanged");
  a_irq_path: assert property (fe && audio_irq // RULE_06
    |=> irq_slot6_valid == $past(q.stage.cfg[ACSCFG_B_IRQ]) && irq_slot12_bit0 != irq_slot6_valid)
    else $error("interrupt steered to wrong slot");
  a_lbk_front: assert property (fe && q.stage.lbk_en // RULE_07
    && q.stage.cfg[ACSCFG_B_LBK+:2] == ACSCFG_LBK_FRONT |=> front_dac_l == $past(adc_l))
    else $error("front loop-back path wrong");
  a_lbk_cl: assert property (fe && q.stage.lbk_en && !q.stage.cfg[ACSCFG_B_SWAP] // RULE_08
    && q.stage.cfg[ACSCFG_B_LBK+:2] == ACSCFG_LBK_CL
    |=> center_pin == $past(adc_l) && lfe_pin == $past(adc_r))
    else $error("center/lfe loop-back path wrong");
  a_lbk_off: assert property (fe && !q.stage.lbk_en // RULE_09
    |=> front_dac_l == $past(link_front_l) && surr_dac_r == $past(link_surr_r))
    else $error("loop-back active while disabled");
  a_mic_route: assert property (fe && q.stage.cfg[ACSCFG_B_MIC+:3] == 3'h5 // RULE_11
    |=> mic_pin_sel == 3'h3)
    else $error("mic and line-in mix not selected");
  a_mic_mix: assert property (fe && q.stage.mix |=> !mic_stereo) // RULE_12
    else $error("stereo mic not suppressed by mix");
  a_frame_hold: assert property (run && !frame_sync ##1 run // RULE_18
    |-> $stable(center_pin) && $stable(mic_pin_sel) && $stable(slot16_mode))
    else $error("steering changed between frames");
  a_mask_map: assert property (fe |=> chain_codec_mask[0] == $past(q.stage.cfg[ACSCFG_B_MASK])) // RULE_13
    else $error("chain mask bit 0 not master");

  c_lbk_cl: cover property (fe && q.stage.lbk_en && q.stage.cfg[ACSCFG_B_LBK+:2] == ACSCFG_LBK_CL);
  c_underrun: cover property (fe && spdif_underrun && q.stage.cfg[ACSCFG_B_FILL]);
  c_new_cfg: cover property (q.req_s != q.ack ##[1:50] fe);
endmodule : acscfg_top

// ===== shared/acscfg_pkg.sv
/*
  constants, field layout and shared types of the audio codec serial configuration block.
  assumes one register bus clock domain and one link bit clock domain.
// Summary of operation
// RULE_01 - link bit 1 ties s/pdif data requests to front dac rate, 0 unlinked
// RULE_02 - on s/pdif underrun repeat last sample, or send midscale when fill bit set
// RULE_03 - software should set equal s/pdif and adc rates when fill bit is set
// RULE_04 - s/pdif source is link stream at 0, digital adc stream at 1
// RULE_05 - swap bit 1 exchanges center and lfe pins
// RULE_06 - interrupt path bit steers interrupt to slot 12 bit 0 or slot 6 valid
// RULE_07 - loop-back code 00 uses front dacs, 01 surround dacs, 11 reserved
// RULE_08 - loop-back code 10 feeds center from adc left, lfe from adc right
// RULE_09 - loop-back selection acts only while loop-back enable is set
// RULE_10 - s/pdif enabled when detect resistor present or override bit set
// RULE_11 - mic source code picks mic, line-in, center/lfe pins or mixes
// RULE_12 - mic source combines with stereo mic select and mic mix control
// RULE_13 - four-bit mask names the chained codec targeted, bit 0 master
// RULE_14 - slot mode bit 1 makes sixteen 16-bit slots per frame
// RULE_15 - soft reset keeps slot mode, mask bits 2:0, override, source, fill, link
// RULE_16 - hardware reset returns every configuration field to default
// RULE_17 - reserved codes read back as written; reserved loop-back keeps normal paths
// RULE_18 - steering changes take effect at the next frame boundary
*/
package acscfg_pkg;
  localparam logic [7:0]  ACSCFG_OFS_CFG  = 8'h00;
  localparam logic [7:0]  ACSCFG_OFS_CTL  = 8'h04;
  localparam logic [7:0]  ACSCFG_OFS_STS  = 8'h08;
  localparam logic [15:0] ACSCFG_CFG_RST  = 16'h1001;
  // the top mask bit is not kept: a soft reset returns it to its default
  localparam logic [15:0] ACSCFG_CFG_KEEP = 16'hf087;
  localparam int ACSCFG_B_LINK   = 0;
  localparam int ACSCFG_B_FILL   = 1;
  localparam int ACSCFG_B_SRC    = 2;
  localparam int ACSCFG_B_SWAP   = 3;
  localparam int ACSCFG_B_IRQ    = 4;
  localparam int ACSCFG_B_LBK    = 5;
  localparam int ACSCFG_B_OVR    = 7;
  localparam int ACSCFG_B_MIC    = 8;
  localparam int ACSCFG_B_MASK3  = 11;
  localparam int ACSCFG_B_MASK   = 12;
  localparam int ACSCFG_B_SLOT16 = 15;
  localparam int ACSCFG_C_LBK    = 0;
  localparam int ACSCFG_C_STEREO = 1;
  localparam int ACSCFG_C_MIX    = 2;
  localparam int ACSCFG_C_SOFT   = 8;
  localparam int ACSCFG_S_SPDIF  = 0;
  localparam int ACSCFG_S_DET    = 1;
  localparam int ACSCFG_S_BUSY   = 2;
  localparam logic [1:0] ACSCFG_LBK_FRONT = 2'h0;
  localparam logic [1:0] ACSCFG_LBK_SURR  = 2'h1;
  localparam logic [1:0] ACSCFG_LBK_CL    = 2'h2;
  localparam int ACSCFG_SAMPLE_W = 20;
  typedef struct packed {
    logic [15:0] cfg;
    logic        lbk_en;
    logic        stereo;
    logic        mix;
  } acscfg_xfer_t;
  localparam acscfg_xfer_t ACSCFG_XFER_RST = '{ACSCFG_CFG_RST, 1'b0, 1'b0, 1'b0};
  typedef enum logic {ACSCFG_HS_IDLE, ACSCFG_HS_BUSY} acscfg_hs_t;
endpackage : acscfg_pkg

// ===== shared/acscfg_if.sv
/*
  carrier between the register side and the link side of the block.
  assumes word stays stable while req_tgl and ack_tgl differ.
*/
`timescale 1ns/10ps
interface acscfg_if;
  import acscfg_pkg::*;
  acscfg_xfer_t word;
  logic         req_tgl;
  logic         ack_tgl;
  modport regs (output word, output req_tgl, input ack_tgl);
  modport link (input word, input req_tgl, output ack_tgl);
endinterface : acscfg_if

// ===== rtl/acscfg_regs.sv
/*
  ahb-lite register slave holding the configuration, control and status words.
  assumes a single master; zero wait states, always okay.
*/
`timescale 1ns/10ps
module acscfg_regs
  import acscfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             spdif_enable,
  input  wire logic        detect_pin,
  acscfg_if.regs           bus
);
  typedef struct packed {
    acscfg_xfer_t cur;
    acscfg_xfer_t xfer;
    acscfg_hs_t   hs;
    logic         req_tgl;
    logic         ack_m;
    logic         ack_s;
    logic         det_m;
    logic         det_s;
    logic         spdif_en;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic [31:0]  rdata;
    logic         ready;
  } acscfg_regs_t;

  acscfg_regs_t q;
  acscfg_regs_t d;

  always_comb begin
    d = q;
    d.det_m = detect_pin;
    d.det_s = q.det_m;
    d.ack_m = bus.ack_tgl;
    d.ack_s = q.ack_m;
    d.ready = 1'b1;
    d.spdif_en = q.cur.cfg[ACSCFG_B_OVR] | q.det_s; // RULE_10
    d.wr_pend = 1'b0;
    if (q.wr_pend) begin
      case (q.wr_addr)
        ACSCFG_OFS_CFG: d.cur.cfg = hwdata[15:0]; // RULE_17
        ACSCFG_OFS_CTL: begin
          d.cur.lbk_en = hwdata[ACSCFG_C_LBK];
          d.cur.stereo = hwdata[ACSCFG_C_STEREO];
          d.cur.mix    = hwdata[ACSCFG_C_MIX];
          if (hwdata[ACSCFG_C_SOFT]) begin
            d.cur.cfg = (q.cur.cfg & ACSCFG_CFG_KEEP) | (ACSCFG_CFG_RST & ~ACSCFG_CFG_KEEP); // RULE_15
          end
        end
        default: ;
      endcase
    end
    case (q.hs)
      ACSCFG_HS_IDLE: if (q.cur != q.xfer) begin
        d.xfer = q.cur;
        d.req_tgl = ~q.req_tgl;
        d.hs = ACSCFG_HS_BUSY;
      end
      ACSCFG_HS_BUSY: if (q.ack_s == q.req_tgl) d.hs = ACSCFG_HS_IDLE;
      default: d.hs = ACSCFG_HS_IDLE;
    endcase
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        d.wr_pend = 1'b1;
        d.wr_addr = haddr;
      end else begin
        // read sees a write completing in the same cycle
        case (haddr)
          ACSCFG_OFS_CFG: d.rdata = {16'h0000, d.cur.cfg};
          ACSCFG_OFS_CTL: d.rdata = {29'h0, d.cur.mix, d.cur.stereo, d.cur.lbk_en};
          ACSCFG_OFS_STS: d.rdata = {29'h0, q.hs == ACSCFG_HS_BUSY, q.det_s, q.spdif_en};
          default:        d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{ACSCFG_XFER_RST, ACSCFG_XFER_RST, ACSCFG_HS_IDLE, 1'b0, 1'b0, 1'b0, 1'b0,
             1'b0, 1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b1}; // RULE_16
    end else if (ce) begin
      q <= d;
    end
  end

  assign hreadyout    = q.ready;
  assign hrdata       = q.rdata;
  assign spdif_enable = q.spdif_en;
  assign bus.word     = q.xfer;
  assign bus.req_tgl  = q.req_tgl;

  a_soft_keep: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
    (ce && q.wr_pend && q.wr_addr == ACSCFG_OFS_CTL && hwdata[ACSCFG_C_SOFT])
    |=> ((q.cur.cfg & ACSCFG_CFG_KEEP) == ($past(q.cur.cfg) & ACSCFG_CFG_KEEP)))
    else $error("soft reset altered a kept field");
  a_spdif_en: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    ce && q.cur.cfg[ACSCFG_B_OVR] |=> spdif_enable)
    else $error("override set but s/pdif not enabled");
  c_soft_rst: cover property (@(posedge clk) disable iff (!reset_n)
    q.wr_pend && q.wr_addr == ACSCFG_OFS_CTL && hwdata[ACSCFG_C_SOFT]);
endmodule : acscfg_regs

// ===== tb/acscfg_link_model.sv
/*
  far-side link controller model: bit clock, frame pulse, sample words and request levels.
  assumes the bench moves seed, underrun and irq only many frames apart.
*/
`timescale 1ns/10ps
module acscfg_link_model
  import acscfg_pkg::*;
#(
  parameter int W     = ACSCFG_SAMPLE_W,
  parameter int FRAME = 8
) (
  output logic         link_clk,
  output logic         frame_sync,
  output logic [W-1:0] smp [10],
  output logic         spdif_underrun,
  output logic         front_rate_req,
  output logic         spdif_rate_req,
  output logic         audio_irq,
  input  wire logic [W-1:0] seed,
  input  wire logic    underrun_on,
  input  wire logic    irq_on
);
  int cnt = 0;

  assign front_rate_req = 1'b1;
  assign spdif_rate_req = 1'b0;
  assign spdif_underrun = underrun_on;
  assign audio_irq      = irq_on;

  // odd start offset keeps the bit clock out of phase with the bus clock
  initial begin
    link_clk = 1'b0;
    frame_sync = 1'b0;
    for (int k = 0; k < 10; k++) smp[k] = '0;
    #3.7;
    forever #16 link_clk = ~link_clk;
  end

  // words are garbled right after the frame edge so stale sampling shows up
  always @(posedge link_clk) begin
    cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
    frame_sync <= (cnt == FRAME - 1);
    for (int k = 0; k < 10; k++) begin
      if (cnt == FRAME - 1) smp[k] <= seed + W'(k);
      else if (cnt == 0) smp[k] <= ~smp[k];
    end
  end
endmodule : acscfg_link_model

// ===== tb/tb.sv
/*
  self-checking bench of the serial configuration block over ahb-lite and the link model.
  assumes zero-wait slave and frame-aligned application of configuration changes.
*/
`timescale 1ns/10ps
module tb
  import acscfg_pkg::*;
;
  localparam int W = ACSCFG_SAMPLE_W;
  logic         clk, reset_n, hsel, hwrite, hrdy, hresp, detect, spen;
  logic         link_clk, fsync, und, frq, srq, irq, und_on, irq_on;
  logic         spreq, i12, i6, mst, slot16;
  logic [1:0]   htrans;
  logic [2:0]   micsel;
  logic [3:0]   mask;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [W-1:0] seed, fdl, fdr, sdl, sdr, cen, lfe, spl, spr;
  logic [W-1:0] smp [10];
  int           err_count = 0, tests_run = 0, cycles = 0;

  acscfg_top #(.W(W)) acscfg_top_inst (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hrdata(hrdata), .hresp(hresp), .spdif_detect_pin(detect), .spdif_enable(spen),
    .link_clk(link_clk), .frame_sync(fsync), .link_front_l(smp[0]), .link_front_r(smp[1]),
    .link_surr_l(smp[2]), .link_surr_r(smp[3]), .link_center(smp[4]), .link_lfe(smp[5]),
    .link_spdif_l(smp[6]), .link_spdif_r(smp[7]), .adc_l(smp[8]), .adc_r(smp[9]),
    .spdif_underrun(und), .front_rate_req(frq), .spdif_rate_req(srq), .audio_irq(irq),
    .front_dac_l(fdl), .front_dac_r(fdr), .surr_dac_l(sdl), .surr_dac_r(sdr),
    .center_pin(cen), .lfe_pin(lfe), .spdif_l(spl), .spdif_r(spr), .spdif_req(spreq),
    .irq_slot12_bit0(i12), .irq_slot6_valid(i6), .mic_pin_sel(micsel), .mic_stereo(mst),
    .chain_codec_mask(mask), .slot16_mode(slot16)
  );

  acscfg_link_model #(.W(W)) acscfg_link_model_inst (
    .link_clk(link_clk), .frame_sync(fsync), .smp(smp), .spdif_underrun(und),
    .front_rate_req(frq), .spdif_rate_req(srq), .audio_irq(irq), .seed(seed),
    .underrun_on(und_on), .irq_on(irq_on)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask : rdc

  // link outputs other than spdif_req hold for a whole frame, so sampling just after the update edge is safe
  task frames(input int n);
    repeat (n) @(posedge fsync);
    @(posedge link_clk);
    #1;
    @(posedge clk);
  endtask : frames

  task apply(input logic [15:0] c, input logic [2:0] t);
    wr(ACSCFG_OFS_CFG, {16'h0, c});
    wr(ACSCFG_OFS_CTL, {29'h0, t});
    frames(4);
  endtask : apply

  function logic [31:0] smpx(input int k);
    return 32'(seed + W'(k));
  endfunction : smpx

  task t_reset;
    rdc(ACSCFG_OFS_CFG, 32'h1001);
    rdc(8'h0c, 32'h0);
    check(32'(micsel), 32'h1);
    check(32'(mask), 32'h1);
    check(32'(spen), 32'h0);
    check(32'(hresp), 32'h0);
    check(32'(slot16), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task t_paths;
    for (int i = 0; i < 2; i++) begin
      apply(i ? 16'h101d : 16'h1000, 3'h0);
      check(32'(spreq), 32'(i));
      check(32'(cen), smpx(i ? 5 : 4));
      check(32'(lfe), smpx(i ? 4 : 5));
      check(32'(spl), smpx(i ? 8 : 6));
      check(32'(spr), smpx(i ? 9 : 7));
      check(32'(i12), 32'(1 - i));
      check(32'(i6), 32'(i));
    end
    $display("test paths done");
  endtask : t_paths

  task t_loop;
    logic       en;
    logic [1:0] code;
    for (int j = 0; j < 5; j++) begin
      en = (j > 0);
      code = (j == 0) ? 2'h2 : 2'(j - 1);
      apply(16'h1001 | {9'h0, code, 5'h0}, {2'h0, en});
      rdc(ACSCFG_OFS_CFG, 32'h1001 | {25'h0, code, 5'h0});
      check(32'(fdl), smpx((en && code == 0) ? 8 : 0));
      check(32'(fdr), smpx((en && code == 0) ? 9 : 1));
      check(32'(sdr), smpx((en && code == 1) ? 9 : 3));
      check(32'(sdl), smpx((en && code == 1) ? 8 : 2));
      check(32'(cen), smpx((en && code == 2) ? 8 : 4));
      check(32'(lfe), smpx((en && code == 2) ? 9 : 5));
    end
    $display("test loopback done");
  endtask : t_loop

  task t_mic;
    logic [2:0] e [8] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h5, 3'h3, 3'h6, 3'h7};
    for (int c = 0; c < 8; c++) begin
      apply(16'h1001 | 16'(c << 8), 3'h0);
      check(32'(micsel), 32'(e[c]));
    end
    for (int c = 0; c < 4; c++) begin
      apply(16'h1001, 3'(c << 1));
      check(32'(mst), 32'(c == 1));
    end
    $display("test mic done");
  endtask : t_mic

  task t_mask;
    logic [15:0] v [4] = '{16'h0801, 16'h2001, 16'h4001, 16'h9081};
    for (int k = 0; k < 4; k++) begin
      apply(v[k], 3'h0);
      check(32'(mask), 32'({v[k][11], v[k][14:12]}));
      check(32'(slot16), 32'(v[k][15]));
      check(32'(spen), 32'(v[k][7]));
    end
    detect <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(ACSCFG_OFS_STS, 32'h3);
    detect <= 1'b0;
    apply(16'h1001, 3'h0);
    check(32'(spen), 32'h0);
    $display("test mask done");
  endtask : t_mask

  task t_soft;
    wr(ACSCFG_OFS_CFG, 32'hffff);
    rdc(ACSCFG_OFS_CFG, 32'hffff);
    wr(ACSCFG_OFS_CTL, 32'h100);
    rdc(ACSCFG_OFS_CFG, 32'h0000_f087);
    apply(16'h1001, 3'h0);
    $display("test soft reset done");
  endtask : t_soft

  task t_under;
    logic [31:0] last;
    last = smpx(6);
    und_on <= 1'b1;
    seed <= seed + 20'h00111;
    frames(4);
    check(32'(spl), last);
    // one frame rate drives both streams here, so the rates stay equal
    apply(16'h1003, 3'h0);
    check(32'(spl), 32'h0008_0000);
    check(32'(spr), 32'h0008_0000);
    und_on <= 1'b0;
    apply(16'h1001, 3'h0);
    $display("test underrun done");
  endtask : t_under

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    detect = 1'b0;
    seed = 20'h12340;
    und_on = 1'b0;
    irq_on = 1'b1;
    repeat (16) @(posedge clk);
    // the link side needs a few of its own edges inside reset as well
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_paths();
    t_loop();
    t_mic();
    t_mask();
    t_soft();
    t_under();
    end_of_test();
  end
endmodule : tb
